// >>> rtl/jir_arith.sv
`timescale 1ns/10ps
module jir_arith (
    jir_if.arith a
);
    logic [15:0] pair;
    logic [15:0] prod;
    logic [15:0] quo_full;

    // Unsigned bottom:middle pair; carries and borrows out of bit 15 drop
    always_comb begin
        pair = {a.bot, a.mid};
        prod = 16'(a.top) * 16'(a.mid);
        a.sum = pair + 16'(a.top);
        a.dif = pair - 16'(a.top);
        a.mac = prod + 16'(a.bot);
        // Zero divisor: all ones, low byte as remainder
        if (a.top == 8'h00) begin
            quo_full = {8'h00, jir_pkg::DIV_ZERO_QUOT};
            a.rem = a.mid;
        end else begin
            quo_full = pair / 16'(a.top);
            a.rem = 8'(pair % 16'(a.top));
        end
        a.quo = quo_full[7:0]; // Quotient overflow wraps to eight bits
    end
endmodule : jir_arith

// >>> rtl/jir_decode.sv
`timescale 1ns/10ps
module jir_decode (
    jir_if.decode dif_port
);
    // Prefix match; five-bit field classes are tested before four-bit ones
    always_comb begin
        dif_port.cls = jir_pkg::CLS_NONE;
        dif_port.sel = dif_port.opcode[jir_pkg::REL_FIELD_MSB:0];
        if (dif_port.opcode[7:5] == jir_pkg::PFX_REL_JUMP) begin
            dif_port.cls = jir_pkg::CLS_REL;
        end else if (dif_port.opcode[7:5] == jir_pkg::PFX_INTER_REG) begin
            dif_port.cls = jir_pkg::CLS_ITR;
        end else if (dif_port.opcode[7:4] == jir_pkg::PFX_DOUBLE_JUMP) begin
            dif_port.cls = jir_pkg::CLS_DBL;
        end else if (dif_port.opcode[7:4] == jir_pkg::PFX_COMPOUND) begin
            dif_port.cls = jir_pkg::CLS_COM;
        end
    end
endmodule : jir_decode

// >>> rtl/jir_if.sv
`timescale 1ns/10ps
// Carries opcode decode and arithmetic results between the core and its helpers
interface jir_if;
    logic [7:0] opcode;
    jir_pkg::class_e cls;
    logic [4:0] sel;
    logic [7:0] top;
    logic [7:0] mid;
    logic [7:0] bot;
    logic [15:0] sum;
    logic [15:0] dif;
    logic [15:0] mac;
    logic [7:0] quo;
    logic [7:0] rem;

    modport decode (input opcode, output cls, output sel);
    modport arith (input top, input mid, input bot,
                   output sum, output dif, output mac, output quo, output rem);
    modport core (output opcode, output top, output mid, output bot,
                  input cls, input sel, input sum, input dif, input mac,
                  input quo, input rem);
endinterface : jir_if

// >>> rtl/jir_pkg.sv
package jir_pkg;

    // Sequencing phase, Gray coded along idle -> operate -> idle
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_OPERATE = 2'b01
    } phase_e;

    // Instruction class seen by the unit
    typedef enum logic [2:0] {
        CLS_NONE = 3'h0,
        CLS_REL = 3'h1,
        CLS_DBL = 3'h2,
        CLS_ITR = 3'h3,
        CLS_COM = 3'h4
    } class_e;

    // Opcode prefixes: three-bit for five-bit fields, four-bit for four-bit fields
    localparam logic [2:0] PFX_REL_JUMP = 3'h1;
    localparam logic [2:0] PFX_INTER_REG = 3'h2;
    localparam logic [3:0] PFX_DOUBLE_JUMP = 4'h8;
    localparam logic [3:0] PFX_COMPOUND = 4'hf;
    localparam int REL_FIELD_MSB = 4;
    localparam int NIB_FIELD_MSB = 3;

    // Inter-register selectors (octal values noted)
    localparam logic [4:0] SEL_SKIP_ZERO = 5'h00;      // 0
    localparam logic [4:0] SEL_SKIP_NONZERO = 5'h01;   // 1
    localparam logic [4:0] SEL_SKIP_NONNEG = 5'h02;    // 2
    localparam logic [4:0] SEL_SWAP_TOP_WORD = 5'h06;  // 6
    localparam logic [4:0] SEL_SWAP_TOP_PAGE = 5'h07;  // 7
    localparam logic [4:0] SEL_CIRC_UP = 5'h08;        // 10
    localparam logic [4:0] SEL_SWAP_WORD_PAGE = 5'h0a; // 12
    localparam logic [4:0] SEL_SWAP_WORD_OFS = 5'h0c;  // 14
    localparam logic [4:0] SEL_ROT_DBL_RIGHT = 5'h11;  // 21
    localparam logic [4:0] SEL_SWAP_NIBBLES = 5'h17;   // 27
    localparam logic [4:0] SEL_COMPLEMENT = 5'h18;     // 30
    localparam logic [4:0] SEL_UNPACK = 5'h19;         // 31
    localparam logic [4:0] SEL_AND = 5'h1a;            // 32
    localparam logic [4:0] SEL_XOR = 5'h1b;            // 33
    localparam logic [4:0] SEL_ADD = 5'h1c;            // 34
    localparam logic [4:0] SEL_SUB = 5'h1d;            // 35
    localparam logic [4:0] SEL_MAC = 5'h1e;            // 36
    localparam logic [4:0] SEL_DIV = 5'h1f;            // 37

    // Compound sub-codes
    localparam logic [3:0] COM_LOAD_COMPL = 4'h0;
    localparam logic [3:0] COM_LAST_LITERAL = 4'h7;

    // Register file selector for the environment write port
    localparam logic [2:0] ENV_TOP = 3'h0;
    localparam logic [2:0] ENV_MID = 3'h1;
    localparam logic [2:0] ENV_BOT = 3'h2;
    localparam logic [2:0] ENV_WORD = 3'h3;
    localparam logic [2:0] ENV_PROG_PAGE = 3'h4;
    localparam logic [2:0] ENV_OFFSET = 3'h5;
    localparam logic [2:0] ENV_DATA_WORD = 3'h6;
    localparam logic [2:0] ENV_DATA_PAGE = 3'h7;

    // Reset values and constants
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] SKIP_STEP = 8'h01;
    localparam logic [7:0] DIV_ZERO_QUOT = 8'hff;

    // Literal compound code to the inter-register selector it runs after the push
    function automatic logic [4:0] com_to_sel(input logic [3:0] code);
        logic [4:0] s;
        s = SEL_UNPACK;
        case (code)
            4'h2: s = SEL_AND;
            4'h3: s = SEL_XOR;
            4'h4: s = SEL_ADD;
            4'h5: s = SEL_SUB;
            4'h6: s = SEL_MAC;
            4'h7: s = SEL_DIV;
            default: s = SEL_UNPACK;
        endcase
        return s;
    endfunction : com_to_sel

endpackage : jir_pkg

// >>> rtl/jump_and_interregister_unit.sv
`timescale 1ns/10ps
// Operation
// - Relative jump adds signed five-bit offset, -16..+15, to word pointer.
// - Relative jump never carries into program page; page wraps circularly.
// - Double jump loads low nibble into page low half, next byte into pointer.
// - Prefix 02 selects 18 inter-register operations, none touching memory.
// - Skip adds one to word pointer only on condition, no carry out.
// - Selector 0 skips on top zero, selector 1 on top nonzero.
// - Selector 2 skips when top register sign bit is clear.
// - Exchange swaps top register with data word pointer in one operation.
// - Selector 7 swaps top register with data page register.
// - Selector 14 swaps data word pointer with data offset register.
// - Selector 12 swaps data word pointer with data page register.
// - Selector 10 circulates stack up: bottom to middle, middle to top, top to bottom.
// - Double right rotate shifts top and middle together, low bits cross over.
// - Selector 27 swaps the two nibbles of the top register.
// - Selector 31 swaps top low nibble with middle high nibble.
// - Selector 30 complements the top register.
// - Selector 32 ANDs middle into top, selector 33 XORs middle into top.
// - Selector 34 adds top to bottom:middle; low to top, high middle, top bottom.
// - Selector 35 subtracts top from bottom:middle with the same placement.
// - Selector 36 multiplies top by middle plus bottom; 37 divides pair by top.
// - Literal compounds push the literal first, then run the matching operation.
// - Literal-complement load pushes inverted literal; old bottom is lost.
// - Memory load pushes the byte onto the stack, old bottom lost.
module jump_and_interregister_unit (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic exec_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] ext_byte,
    input wire logic load_valid,
    input wire logic [7:0] load_data,
    input wire logic env_wr,
    input wire logic [2:0] env_sel,
    input wire logic [7:0] env_data,
    output logic busy,
    output logic done,
    output logic skip_taken,
    output logic [7:0] top_reg,
    output logic [7:0] mid_reg,
    output logic [7:0] bot_reg,
    output logic [7:0] word_ptr,
    output logic [7:0] prog_page,
    output logic [7:0] data_offset,
    output logic [7:0] data_word_ptr,
    output logic [7:0] data_page
);

    // Whole architectural state of the unit
    typedef struct packed {
        jir_pkg::phase_e phase;
        logic [4:0] pend_sel;
        logic [7:0] top;
        logic [7:0] mid;
        logic [7:0] bot;
        logic [7:0] word;
        logic [7:0] page;
        logic [7:0] ofs;
        logic [7:0] dword;
        logic [7:0] dpage;
        logic done;
        logic skip;
    } unit_s;

    unit_s st_ff;
    unit_s nxt_st;
    jir_if bus_if ();

    jir_decode u_decode (
        .dif_port(bus_if)
    );

    jir_arith u_arith (
        .a(bus_if)
    );

    // Helpers always see the registered stack, so a compound second phase
    // operates on the already pushed literal
    assign bus_if.opcode = opcode;
    assign bus_if.top = st_ff.top;
    assign bus_if.mid = st_ff.mid;
    assign bus_if.bot = st_ff.bot;

    // Push a byte onto the stack; the old bottom is discarded
    function automatic unit_s push(input unit_s s, input logic [7:0] val);
        unit_s r;
        r = s;
        r.top = val;
        r.mid = s.top;
        r.bot = s.mid;
        return r;
    endfunction : push

    // One inter-register operation; unlisted selectors leave state unchanged
    function automatic unit_s apply_itr(
        input unit_s s,
        input logic [4:0] sel,
        input logic [15:0] sum,
        input logic [15:0] dif,
        input logic [15:0] mac,
        input logic [7:0] quo,
        input logic [7:0] rem
    );
        unit_s r;
        logic cond;
        r = s;
        cond = 1'b0;
        case (sel)
            jir_pkg::SEL_SKIP_ZERO: begin
                cond = (s.top == 8'h00);
            end
            jir_pkg::SEL_SKIP_NONZERO: begin
                cond = (s.top != 8'h00);
            end
            jir_pkg::SEL_SKIP_NONNEG: begin
                cond = ~s.top[7];
            end
            jir_pkg::SEL_SWAP_TOP_WORD: begin
                r.top = s.dword;
                r.dword = s.top;
            end
            jir_pkg::SEL_SWAP_TOP_PAGE: begin
                r.top = s.dpage;
                r.dpage = s.top;
            end
            jir_pkg::SEL_CIRC_UP: begin
                r.top = s.mid;
                r.mid = s.bot;
                r.bot = s.top;
            end
            jir_pkg::SEL_SWAP_WORD_PAGE: begin
                r.dword = s.dpage;
                r.dpage = s.dword;
            end
            jir_pkg::SEL_SWAP_WORD_OFS: begin
                r.dword = s.ofs;
                r.ofs = s.dword;
            end
            jir_pkg::SEL_ROT_DBL_RIGHT: begin
                r.top = {s.mid[0], s.top[7:1]};
                r.mid = {s.top[0], s.mid[7:1]};
            end
            jir_pkg::SEL_SWAP_NIBBLES: begin
                r.top = {s.top[3:0], s.top[7:4]};
            end
            jir_pkg::SEL_COMPLEMENT: begin
                r.top = ~s.top;
            end
            jir_pkg::SEL_UNPACK: begin
                r.top = {s.top[7:4], s.mid[7:4]};
                r.mid = {s.top[3:0], s.mid[3:0]};
            end
            jir_pkg::SEL_AND: begin
                r.top = s.top & s.mid;
            end
            jir_pkg::SEL_XOR: begin
                r.top = s.top ^ s.mid;
            end
            jir_pkg::SEL_ADD: begin
                r.top = sum[7:0];
                r.mid = sum[15:8];
                r.bot = s.top;
            end
            jir_pkg::SEL_SUB: begin
                r.top = dif[7:0];
                r.mid = dif[15:8];
                r.bot = s.top;
            end
            jir_pkg::SEL_MAC: begin
                r.top = mac[7:0];
                r.mid = mac[15:8];
                r.bot = s.top;
            end
            jir_pkg::SEL_DIV: begin
                r.top = quo;
                r.mid = rem;
                r.bot = s.top;
            end
            default: begin
                r = s; // Selectors outside this unit act as no-ops
            end
        endcase
        // Skip stays inside the page, eight-bit wrap only
        if (cond) begin
            r.word = s.word + jir_pkg::SKIP_STEP;
        end
        r.skip = cond;
        return r;
    endfunction : apply_itr

    // Next state: execute beats load beats environment write
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        nxt_st.skip = 1'b0;
        unique case (st_ff.phase)
            jir_pkg::PH_IDLE: begin
                if (exec_valid) begin
                    nxt_st.done = 1'b1;
                    case (bus_if.cls)
                        jir_pkg::CLS_REL: begin
                            // Sign-extended offset, no carry toward the page
                            nxt_st.word = st_ff.word
                                + {{3{opcode[jir_pkg::REL_FIELD_MSB]}},
                                   opcode[jir_pkg::REL_FIELD_MSB:0]};
                        end
                        jir_pkg::CLS_DBL: begin
                            nxt_st.page = {st_ff.page[7:4],
                                           opcode[jir_pkg::NIB_FIELD_MSB:0]};
                            nxt_st.word = ext_byte;
                        end
                        jir_pkg::CLS_ITR: begin
                            nxt_st = apply_itr(st_ff, bus_if.sel, bus_if.sum, bus_if.dif,
                                               bus_if.mac, bus_if.quo, bus_if.rem);
                            nxt_st.done = 1'b1;
                        end
                        jir_pkg::CLS_COM: begin
                            if (opcode[3:0] == jir_pkg::COM_LOAD_COMPL) begin
                                nxt_st = push(st_ff, ~ext_byte);
                                nxt_st.done = 1'b1;
                            end else if (opcode[3:0] <= jir_pkg::COM_LAST_LITERAL) begin
                                // Push now, operate next cycle on the pushed stack
                                nxt_st = push(st_ff, ext_byte);
                                nxt_st.pend_sel = jir_pkg::com_to_sel(opcode[3:0]);
                                nxt_st.phase = jir_pkg::PH_OPERATE;
                                nxt_st.done = 1'b0;
                            end
                        end
                        default: begin
                            nxt_st.done = 1'b1; // Foreign opcodes just complete
                        end
                    endcase
                end else if (load_valid) begin
                    nxt_st = push(st_ff, load_data);
                end else if (env_wr) begin
                    case (env_sel)
                        jir_pkg::ENV_TOP: nxt_st.top = env_data;
                        jir_pkg::ENV_MID: nxt_st.mid = env_data;
                        jir_pkg::ENV_BOT: nxt_st.bot = env_data;
                        jir_pkg::ENV_WORD: nxt_st.word = env_data;
                        jir_pkg::ENV_PROG_PAGE: nxt_st.page = env_data;
                        jir_pkg::ENV_OFFSET: nxt_st.ofs = env_data;
                        jir_pkg::ENV_DATA_WORD: nxt_st.dword = env_data;
                        default: nxt_st.dpage = env_data;
                    endcase
                end
            end
            jir_pkg::PH_OPERATE: begin
                // Second phase of a literal compound; all inputs ignored here
                nxt_st = apply_itr(st_ff, st_ff.pend_sel, bus_if.sum, bus_if.dif,
                                   bus_if.mac, bus_if.quo, bus_if.rem);
                nxt_st.phase = jir_pkg::PH_IDLE;
                nxt_st.done = 1'b1;
            end
            default: begin
                nxt_st.phase = jir_pkg::PH_IDLE; // Recover from an illegal code
            end
        endcase
    end

    // State register; all fields clear on reset
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '{phase: jir_pkg::PH_IDLE, pend_sel: 5'h00,
                       top: jir_pkg::REG_RESET, mid: jir_pkg::REG_RESET,
                       bot: jir_pkg::REG_RESET, word: jir_pkg::REG_RESET,
                       page: jir_pkg::REG_RESET, ofs: jir_pkg::REG_RESET,
                       dword: jir_pkg::REG_RESET, dpage: jir_pkg::REG_RESET,
                       done: 1'b0, skip: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Outputs come straight from the state flops
    assign busy = (st_ff.phase == jir_pkg::PH_OPERATE);
    assign done = st_ff.done;
    assign skip_taken = st_ff.skip;
    assign top_reg = st_ff.top;
    assign mid_reg = st_ff.mid;
    assign bot_reg = st_ff.bot;
    assign word_ptr = st_ff.word;
    assign prog_page = st_ff.page;
    assign data_offset = st_ff.ofs;
    assign data_word_ptr = st_ff.dword;
    assign data_page = st_ff.dpage;

endmodule : jump_and_interregister_unit

// >>> tb/fetch_model.sv
`timescale 1ns/10ps
// Fetch sequencer stand-in
module fetch_model (
    input wire logic clk,
    input wire logic done,
    output logic exec_valid,
    output logic [7:0] opcode,
    output logic [7:0] ext_byte
);
    initial begin
        exec_valid = 1'b0;
        opcode = 8'h00;
        ext_byte = 8'h00;
    end

    // One-cycle request; idle lines inverted
    task automatic issue(input logic [7:0] op, input logic [7:0] ext, output logic ok);
        int n;
        @(posedge clk);
        #1;
        exec_valid = 1'b1;
        opcode = op;
        ext_byte = ext;
        @(posedge clk);
        #1;
        exec_valid = 1'b0;
        opcode = ~op;
        ext_byte = ~ext;
        n = 0;
        while (done !== 1'b1 && n < 3) begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = done;
    endtask : issue
endmodule : fetch_model

// >>> tb/jir_asserts.sv
`timescale 1ns/10ps
module jir_asserts (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic exec_valid,
    input wire logic [7:0] opcode,
    input wire logic [7:0] ext_byte,
    input wire logic load_valid,
    input wire logic [7:0] load_data,
    input wire logic env_wr,
    input wire logic [2:0] env_sel,
    input wire logic [7:0] env_data,
    input wire logic busy,
    input wire logic done,
    input wire logic skip_taken,
    input wire logic [7:0] top_reg,
    input wire logic [7:0] mid_reg,
    input wire logic [7:0] bot_reg,
    input wire logic [7:0] word_ptr,
    input wire logic [7:0] prog_page,
    input wire logic [7:0] data_offset,
    input wire logic [7:0] data_word_ptr,
    input wire logic [7:0] data_page
);
    logic go, rel, dbl, inter_register_group, lit, sk;
    logic [7:0] wp_rel, wp_skip, pg_dbl;
    logic [15:0] sum16;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Decode mirror; ignored while busy
    assign go = exec_valid && !busy;
    assign rel = go && opcode[7:5] == 3'h1;
    assign dbl = go && opcode[7:4] == 4'h8;
    assign inter_register_group = go && opcode[7:5] == 3'h2;
    assign lit = go && opcode[7:4] == 4'hf && opcode[3:0] != 4'h0 && !opcode[3];
    assign sk = (opcode[4:0] == 5'h00 && top_reg == 8'h00)
        || (opcode[4:0] == 5'h01 && top_reg != 8'h00) || (opcode[4:0] == 5'h02 && !top_reg[7]);
    assign wp_rel = word_ptr + {{3{opcode[4]}}, opcode[4:0]};
    assign wp_skip = word_ptr + {7'h00, sk};
    assign pg_dbl = {prog_page[7:4], opcode[3:0]};
    assign sum16 = {bot_reg, mid_reg} + {8'h00, top_reg};

    a_rel_jump: assert property (
        rel |=> done && word_ptr == $past(wp_rel) && $stable(prog_page))
        else $error("relative jump target wrong");
    a_dbl_jump: assert property (
        dbl |=> done && word_ptr == $past(ext_byte) && prog_page == $past(pg_dbl))
        else $error("double jump target wrong");
    a_skip_step: assert property (
        inter_register_group && opcode[4:0] <= 5'h02 |=> skip_taken == $past(sk) && word_ptr == $past(wp_skip))
        else $error("skip decision wrong");
    a_top_page: assert property (
        inter_register_group && opcode[4:0] == 5'h07 |=> top_reg == $past(data_page) && data_page == $past(top_reg))
        else $error("top and data page not swapped");
    a_circ_up: assert property (
        inter_register_group && opcode[4:0] == 5'h08
        |=> top_reg == $past(mid_reg) && mid_reg == $past(bot_reg) && bot_reg == $past(top_reg))
        else $error("stack circulation wrong");
    a_add_wrap: assert property (
        inter_register_group && opcode[4:0] == 5'h1c |=> {mid_reg, top_reg} == $past(sum16) && bot_reg == $past(top_reg))
        else $error("add result wrong");
    a_load_push: assert property (
        load_valid && !exec_valid && !busy
        |=> !done && top_reg == $past(load_data) && mid_reg == $past(top_reg) && bot_reg == $past(mid_reg))
        else $error("load push wrong");
    a_lit_seq: assert property (
        lit |=> busy && !done && top_reg == $past(ext_byte) && mid_reg == $past(top_reg) ##1 done && !busy)
        else $error("literal push sequence wrong");
    a_load_compl: assert property (
        go && opcode == 8'hf0 |=> done && top_reg == ~$past(ext_byte) && mid_reg == $past(top_reg))
        else $error("complement load wrong");

    // Main scenarios reached
    c_lit: cover property (lit ##2 done);
    c_skip: cover property (inter_register_group ##1 skip_taken);
    c_rel: cover property (rel ##1 done);
endmodule : jir_asserts

bind jump_and_interregister_unit jir_asserts u_chk (.clk(clk), .rst_b(rst_b),
    .exec_valid(exec_valid), .opcode(opcode), .ext_byte(ext_byte), .load_valid(load_valid),
    .load_data(load_data), .env_wr(env_wr), .env_sel(env_sel), .env_data(env_data),
    .busy(busy), .done(done), .skip_taken(skip_taken), .top_reg(top_reg), .mid_reg(mid_reg),
    .bot_reg(bot_reg), .word_ptr(word_ptr), .prog_page(prog_page), .data_offset(data_offset),
    .data_word_ptr(data_word_ptr), .data_page(data_page));

// >>> tb/jump_and_interregister_unit_tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module jump_and_interregister_unit_tb;
    logic clk, rst_b, exec_valid, load_valid, env_wr, busy, done, skip_taken, ok;
    logic [7:0] opcode, ext_byte, load_data, env_data, st, sm, sb;
    logic [7:0] top_reg, mid_reg, bot_reg, word_ptr, prog_page;
    logic [7:0] data_offset, data_word_ptr, data_page;
    logic [2:0] env_sel;
    int n_mismatch = 0;
    int samples_checked = 0;

    jump_and_interregister_unit DUT (.clk(clk), .rst_b(rst_b), .exec_valid(exec_valid),
        .opcode(opcode), .ext_byte(ext_byte), .load_valid(load_valid), .load_data(load_data),
        .env_wr(env_wr), .env_sel(env_sel), .env_data(env_data), .busy(busy), .done(done),
        .skip_taken(skip_taken), .top_reg(top_reg), .mid_reg(mid_reg), .bot_reg(bot_reg),
        .word_ptr(word_ptr), .prog_page(prog_page), .data_offset(data_offset),
        .data_word_ptr(data_word_ptr), .data_page(data_page));
    fetch_model u_fetch (.clk(clk), .done(done), .exec_valid(exec_valid), .opcode(opcode),
        .ext_byte(ext_byte));

    // 125 MHz
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic finish_test();
        if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    // Expected {top, mid, bot} after one operation
    function automatic logic [23:0] ref_op(input logic [4:0] s, input logic [7:0] t,
            input logic [7:0] m, input logic [7:0] b);
        logic [15:0] r;
        logic [15:0] q;
        r = {b, m};
        q = 16'h0000;
        case (s)
            5'h08: return {m, b, t};
            5'h11: return {m[0], t[7:1], t[0], m[7:1], b};
            5'h17: return {t[3:0], t[7:4], m, b};
            5'h18: return {~t, m, b};
            5'h19: return {t[7:4], m[7:4], t[3:0], m[3:0], b};
            5'h1a: return {t & m, m, b};
            5'h1b: return {t ^ m, m, b};
            5'h1c: q = r + {8'h00, t};
            5'h1d: q = r - {8'h00, t};
            5'h1e: q = {8'h00, b} + {8'h00, t} * {8'h00, m};
            default: begin
                if (t == 8'h00) return {8'hff, m, t};
                q[15:8] = 8'(r % {8'h00, t});
                q[7:0] = 8'(r / {8'h00, t});
            end
        endcase
        return {q[7:0], q[15:8], t};
    endfunction : ref_op

    // Load or env write, then a spare cycle
    task automatic put(input logic ld, input logic [2:0] s, input logic [7:0] d);
        @(posedge clk);
        #1;
        load_valid = ld;
        env_wr = !ld;
        env_sel = s;
        env_data = d;
        load_data = d;
        @(posedge clk);
        #1;
        load_valid = 1'b0;
        env_wr = 1'b0;
        env_sel = ~s;
        env_data = ~d;
        load_data = ~d;
        @(posedge clk);
        #1;
    endtask : put

    task automatic stack(input logic [7:0] t, input logic [7:0] m, input logic [7:0] b);
        put(1'b1, 3'h0, b);
        put(1'b1, 3'h0, m);
        put(1'b1, 3'h0, t);
        `CHK({top_reg, mid_reg, bot_reg}, {t, m, b})
        {st, sm, sb} = {t, m, b};
    endtask : stack

    task automatic ex(input logic [7:0] op, input logic [7:0] ext);
        u_fetch.issue(op, ext, ok);
        `CHK(ok, 1'b1)
    endtask : ex

    task automatic itr_step(input logic [4:0] s);
        logic [23:0] e;
        e = ref_op(s, st, sm, sb);
        ex({3'h2, s}, 8'h00);
        `CHK({top_reg, mid_reg, bot_reg}, e)
        {st, sm, sb} = e;
    endtask : itr_step

    task automatic t_reset();
        `CHK({busy, done, skip_taken, top_reg, mid_reg, bot_reg, word_ptr, prog_page, data_offset, data_word_ptr, data_page}, 67'h0)
    endtask : t_reset

    // Offset extremes across the page edge
    task automatic t_jumps();
        put(1'b0, 3'h3, 8'hfe);
        put(1'b0, 3'h4, 8'h37);
        ex(8'h2f, 8'h00);
        `CHK({prog_page, word_ptr}, 16'h370d)
        ex(8'h30, 8'h00);
        `CHK({prog_page, word_ptr}, 16'h37fd)
        ex(8'h85, 8'h40);
        `CHK({prog_page, word_ptr}, 16'h3540)
    endtask : t_jumps

    // Rows {top, selector, skip}; pointer at 0xff so a taken skip wraps
    task automatic t_skips();
        logic [13:0] row [5] = '{{8'h00, 5'h00, 1'b1}, {8'h80, 5'h01, 1'b1},
            {8'h80, 5'h02, 1'b0}, {8'h7f, 5'h02, 1'b1}, {8'h00, 5'h01, 1'b0}};
        for (int i = 0; i < 5; i++) begin
            put(1'b1, 3'h0, row[i][13:6]);
            put(1'b0, 3'h3, 8'hff);
            ex({3'h2, row[i][5:1]}, 8'h00);
            `CHK({skip_taken, word_ptr}, {row[i][0], row[i][0] ? 8'h00 : 8'hff})
        end
    endtask : t_skips

    task automatic t_swaps();
        put(1'b1, 3'h0, 8'h11);
        put(1'b0, 3'h6, 8'h22);
        put(1'b0, 3'h7, 8'h33);
        put(1'b0, 3'h5, 8'h44);
        ex(8'h46, 8'h00);
        `CHK({top_reg, data_word_ptr}, 16'h2211)
        ex(8'h47, 8'h00);
        `CHK({top_reg, data_page}, 16'h3322)
        ex(8'h4c, 8'h00);
        `CHK({data_word_ptr, data_offset}, 16'h4411)
        ex(8'h4a, 8'h00);
        `CHK({data_word_ptr, data_page}, 16'h2244)
    endtask : t_swaps

    // Chains, then carry, borrow and zero-divisor corners
    task automatic t_stack();
        logic [4:0] ops [11] = '{5'h08, 5'h11, 5'h17, 5'h19, 5'h18, 5'h1a, 5'h1b,
            5'h1c, 5'h1d, 5'h1e, 5'h1f};
        stack(8'ha5, 8'h3c, 8'h81);
        foreach (ops[i]) itr_step(ops[i]);
        stack(8'h01, 8'hff, 8'hff);
        itr_step(5'h1c);
        stack(8'ha5, 8'h00, 8'h00);
        itr_step(5'h1d);
        stack(8'h00, 8'h12, 8'h34);
        itr_step(5'h1f);
    endtask : t_stack

    // Every literal compound, the divide last with a zero literal
    task automatic t_literals();
        logic [4:0] lsel [7] = '{5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
        logic [23:0] e;
        logic [7:0] lv;
        stack(8'h5a, 8'hc3, 8'h96);
        for (int k = 1; k < 8; k++) begin
            lv = (k == 7) ? 8'h00 : 8'(8'h2b * k);
            e = ref_op(lsel[k-1], lv, st, sm);
            ex({4'hf, 4'(k)}, lv);
            `CHK({busy, top_reg, mid_reg, bot_reg}, {1'b0, e})
            {st, sm, sb} = e;
        end
        ex(8'hf0, 8'h5a);
        `CHK({top_reg, mid_reg, bot_reg}, {8'ha5, st, sm})
    endtask : t_literals

    initial begin
        rst_b = 1'b0;
        load_valid = 1'b0;
        load_data = 8'h00;
        env_wr = 1'b0;
        env_sel = 3'h0;
        env_data = 8'h00;
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_reset();
        t_jumps();
        t_skips();
        t_swaps();
        t_stack();
        t_literals();
        finish_test();
    end

    // About 180 cycles needed; ample margin
    initial begin
        #40000;
        n_mismatch++;
        finish_test();
    end
endmodule : jump_and_interregister_unit_tb
